// File: fsim_pkg.sv
// Constants for the framer status and interrupt mask block
package fsim_pkg;
	// ==========================================================
	// Register offsets and the mask reset value
	localparam logic [7:0] ALARM_STATUS_ADDR   = 8'h06;
	localparam logic [7:0] EVENT_STATUS_ADDR   = 8'h07;
	localparam logic [7:0] ALARM_IRQ_MASK_ADDR = 8'h16;
	localparam logic [7:0] EVENT_IRQ_MASK_ADDR = 8'h17;
	localparam logic [7:0] CTRL_ADDR           = 8'h1A;
	localparam logic [7:0] MASK_RESET          = 8'h00;
	// ==========================================================
	// Event status bit positions
	localparam int EV_RX_CAS_MF   = 7;
	localparam int EV_RX_ALIGN    = 6;
	localparam int EV_TX_MF       = 5;
	localparam int EV_TICK        = 4;
	localparam int EV_TX_ALIGN    = 3;
	localparam int EV_TX_CLK_LOSS = 2;
	localparam int EV_RX_CRC4_MF  = 1;
	localparam int EV_TX_SLIP     = 0;
	// Alarm status bit positions
	localparam int AL_CARRIER_LOSS = 1;
	localparam int AL_RX_SLIP      = 4;
	// Control register bit positions
	localparam int CTRL_TICK_SEL  = 0;
	localparam int CTRL_CRC4_EN   = 1;
	// ==========================================================
	// Timing
	localparam int CLK_MHZ         = 100;
	localparam int FRAME_US        = 250;     // align frame pair period
	localparam int FRAME_CYC       = FRAME_US * CLK_MHZ;
	localparam int MF_MS           = 2;
	localparam int MF_CYC          = MF_MS * 1000 * CLK_MHZ;
	localparam int TICK_SHORT_US   = 62500;   // 62.5 ms
	localparam int TICK_SHORT_CYC  = TICK_SHORT_US * CLK_MHZ;
	localparam int TICK_LONG_MS    = 1000;
	localparam int TICK_LONG_CYC   = TICK_LONG_MS * 1000 * CLK_MHZ;
	localparam int CH_TIME_NS      = 3900;    // one channel time, longest
	localparam int CH_TIME_CYC     = CH_TIME_NS * CLK_MHZ / 1000;
	localparam int CL_WINDOW_BITS  = 255;
	localparam int CL_MIN_ONES     = 32;
endpackage : fsim_pkg

// File: fsim_top.sv
// Framer status flags, interrupt masks and host interrupt
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
module fsim_top #(
	parameter int FRAME_CYCLES = fsim_pkg::FRAME_CYC,
	parameter int MF_CYCLES    = fsim_pkg::MF_CYC,
	parameter int TICK_S_CYC   = fsim_pkg::TICK_SHORT_CYC,
	parameter int TICK_L_CYC   = fsim_pkg::TICK_LONG_CYC
) (
	// Clock and reset
	input  wire logic       i_core_clk,
	input  wire logic       i_reset,
	// Register port
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	// Receive side events
	input  wire logic       i_rx_bit_en,
	input  wire logic       i_rx_data,
	input  wire logic       i_rx_crc4_mf,
	input  wire logic       i_rx_cas_mf,
	input  wire logic       i_rx_slip,
	input  wire logic [7:0] i_rx_alarms,
	// Transmit side events
	input  wire logic       i_tx_line_clock,
	input  wire logic       i_tx_align,
	input  wire logic       i_tx_slip,
	// Interrupt
	output logic            o_irq
);
	// ==========================================================
	// Parameter check; a period below 2 would leave a flag source stuck high
	if (FRAME_CYCLES < 2 || MF_CYCLES < 2 ||
	    TICK_S_CYC < 2 || TICK_L_CYC < 2) begin : g_bad_period
		$error("fsim_top: period parameters must be at least 2");
	end

	// ==========================================================
	// Registers
	logic [7:0]  alarm_status_reg;
	logic [7:0]  event_status_reg;
	logic [7:0]  alarm_irq_mask_reg;
	logic [7:0]  event_irq_mask_reg;
	logic [7:0]  ctrl_reg;
	logic [31:0] frame_cnt_reg;
	logic [31:0] tx_mf_cnt_reg;
	logic [31:0] crc_mf_cnt_reg;
	logic [31:0] tick_cnt_reg;
	logic [15:0] clk_idle_reg;
	logic        tx_line_clock_prev_reg;
	logic        clk_lost_reg;
	logic [7:0]  cl_win_reg;
	logic [7:0]  cl_ones_reg;
	logic [7:0]  ev_set;
	logic [7:0]  al_live;
	logic        rd_event;
	logic        rd_alarm;
	logic [31:0] tick_limit;

	assign rd_event   = i_rd && (i_addr == fsim_pkg::EVENT_STATUS_ADDR);
	assign rd_alarm   = i_rd && (i_addr == fsim_pkg::ALARM_STATUS_ADDR);
	assign tick_limit = ctrl_reg[fsim_pkg::CTRL_TICK_SEL] ? TICK_S_CYC : TICK_L_CYC;

	// ==========================================================
	// Host writes to masks and control
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			alarm_irq_mask_reg <= fsim_pkg::MASK_RESET;
			event_irq_mask_reg <= fsim_pkg::MASK_RESET;
			ctrl_reg           <= fsim_pkg::MASK_RESET;
		end else if (i_wr) begin
			if (i_addr == fsim_pkg::ALARM_IRQ_MASK_ADDR)
				alarm_irq_mask_reg <= i_wdata;
			if (i_addr == fsim_pkg::EVENT_IRQ_MASK_ADDR)
				event_irq_mask_reg <= i_wdata;
			if (i_addr == fsim_pkg::CTRL_ADDR)
				ctrl_reg <= i_wdata;
		end
	end

	// Receive frame timer, align frame every 250 us
	always_ff @(posedge i_core_clk) begin
		if (i_reset)
			frame_cnt_reg <= 32'h0;
		else if (frame_cnt_reg == 32'(FRAME_CYCLES - 1))
			frame_cnt_reg <= 32'h0;
		else
			frame_cnt_reg <= frame_cnt_reg + 32'h1;
	end

	// Transmit multiframe timer, runs regardless of CRC4
	always_ff @(posedge i_core_clk) begin
		if (i_reset)
			tx_mf_cnt_reg <= 32'h0;
		else if (tx_mf_cnt_reg == 32'(MF_CYCLES - 1))
			tx_mf_cnt_reg <= 32'h0;
		else
			tx_mf_cnt_reg <= tx_mf_cnt_reg + 32'h1;
	end

	// Free-running CRC4 boundary used when CRC4 is off
	always_ff @(posedge i_core_clk) begin
		if (i_reset)
			crc_mf_cnt_reg <= 32'h0;
		else if (crc_mf_cnt_reg == 32'(MF_CYCLES - 1))
			crc_mf_cnt_reg <= 32'h0;
		else
			crc_mf_cnt_reg <= crc_mf_cnt_reg + 32'h1;
	end

	// Timer tick; restarting on a select change would lose phase, so it does not
	always_ff @(posedge i_core_clk) begin
		if (i_reset)
			tick_cnt_reg <= 32'h0;
		else if (tick_cnt_reg >= tick_limit - 32'h1)
			tick_cnt_reg <= 32'h0;
		else
			tick_cnt_reg <= tick_cnt_reg + 32'h1;
	end

	// Transmit clock watchdog, line clock sampled as a level
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			tx_line_clock_prev_reg <= 1'b0;
			clk_idle_reg  <= 16'h0;
			clk_lost_reg  <= 1'b0;
		end else begin
			tx_line_clock_prev_reg <= i_tx_line_clock;
			if (i_tx_line_clock != tx_line_clock_prev_reg) begin
				clk_idle_reg <= 16'h0;
				clk_lost_reg <= 1'b0;
			end else if (clk_idle_reg == 16'(fsim_pkg::CH_TIME_CYC - 1)) begin
				clk_lost_reg <= 1'b1;
			end else begin
				clk_idle_reg <= clk_idle_reg + 16'h1;
			end
		end
	end

	// Carrier loss release window: 32 ones within the first 254 bits of each 255-bit window
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			cl_win_reg  <= 8'h0;
			cl_ones_reg <= 8'h0;
		end else if (i_rx_bit_en) begin
			if (cl_win_reg == 8'(fsim_pkg::CL_WINDOW_BITS - 1)) begin
				cl_win_reg  <= 8'h0;
				cl_ones_reg <= 8'h0;
			end else begin
				cl_win_reg  <= cl_win_reg + 8'h1;
				cl_ones_reg <= cl_ones_reg + {7'h0, i_rx_data};
			end
		end
	end

	// Event sources for the event status register
	always_comb begin
		ev_set = 8'h00;
		ev_set[fsim_pkg::EV_RX_CAS_MF]   = i_rx_cas_mf;
		ev_set[fsim_pkg::EV_RX_ALIGN]    = (frame_cnt_reg == 32'h0);
		ev_set[fsim_pkg::EV_TX_MF]       = (tx_mf_cnt_reg == 32'h0);
		ev_set[fsim_pkg::EV_TICK]        = (tick_cnt_reg == 32'h0);
		ev_set[fsim_pkg::EV_TX_ALIGN]    = i_tx_align;
		ev_set[fsim_pkg::EV_TX_CLK_LOSS] = clk_lost_reg;
		ev_set[fsim_pkg::EV_RX_CRC4_MF]  = ctrl_reg[fsim_pkg::CTRL_CRC4_EN] ?
			i_rx_crc4_mf : (crc_mf_cnt_reg == 32'h0);
		ev_set[fsim_pkg::EV_TX_SLIP]     = i_tx_slip;
	end

	// Alarm conditions; carrier loss holds until the ones criterion is met
	always_comb begin
		al_live = i_rx_alarms;
		al_live[fsim_pkg::AL_RX_SLIP] = i_rx_slip;
		al_live[fsim_pkg::AL_CARRIER_LOSS] = i_rx_alarms[fsim_pkg::AL_CARRIER_LOSS] ||
			(alarm_status_reg[fsim_pkg::AL_CARRIER_LOSS] &&
			 cl_ones_reg < 8'(fsim_pkg::CL_MIN_ONES));
	end

	// Sticky status; set wins over the read clear
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			event_status_reg <= 8'h00;
			alarm_status_reg <= 8'h00;
		end else begin
			event_status_reg <= (rd_event ? 8'h00 : event_status_reg) | ev_set;
			alarm_status_reg <= (rd_alarm ? 8'h00 : alarm_status_reg) | al_live;
		end
	end

	// Read data, valid the cycle after the strobe
	always_ff @(posedge i_core_clk) begin
		if (i_reset)
			o_rdata <= 8'h00;
		else if (i_rd) begin
			unique case (i_addr)
				fsim_pkg::ALARM_STATUS_ADDR:   o_rdata <= alarm_status_reg;
				fsim_pkg::EVENT_STATUS_ADDR:   o_rdata <= event_status_reg;
				fsim_pkg::ALARM_IRQ_MASK_ADDR: o_rdata <= alarm_irq_mask_reg;
				fsim_pkg::EVENT_IRQ_MASK_ADDR: o_rdata <= event_irq_mask_reg;
				fsim_pkg::CTRL_ADDR:           o_rdata <= ctrl_reg;
				default:                       o_rdata <= 8'h00;
			endcase
		end else
			o_rdata <= 8'h00;
	end

	// Interrupt from masked flags, one cycle behind status
	always_ff @(posedge i_core_clk) begin
		if (i_reset)
			o_irq <= 1'b0;
		else
			o_irq <= |(alarm_status_reg & alarm_irq_mask_reg)
			       | |(event_status_reg & event_irq_mask_reg);
	end

	// ==========================================================
	// Assertions
	sequence s_status_read;
		rd_event ##1 1'b1;
	endsequence

	a_irq_follows_mask: assert property (@(posedge i_core_clk) disable iff (i_reset)
		o_irq == $past(|(alarm_status_reg & alarm_irq_mask_reg) |
		               |(event_status_reg & event_irq_mask_reg)))
		else $error("interrupt does not match masked flags");
	a_event_mask_gate: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(event_irq_mask_reg == 8'h00 && alarm_irq_mask_reg == 8'h00) ##1
		(event_irq_mask_reg == 8'h00 && alarm_irq_mask_reg == 8'h00) |-> !o_irq)
		else $error("interrupt raised while all masked");
	a_alarm_mask_gate: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(alarm_status_reg & alarm_irq_mask_reg) != 8'h00 |=> o_irq)
		else $error("unmasked alarm gave no interrupt");
	a_read_clears: assert property (@(posedge i_core_clk) disable iff (i_reset)
		s_status_read |-> event_status_reg == $past(ev_set))
		else $error("event status not cleared by read");
	a_align_period: assert property (@(posedge i_core_clk) disable iff (i_reset)
		!i_reset && ev_set[fsim_pkg::EV_RX_ALIGN] |=> !ev_set[fsim_pkg::EV_RX_ALIGN])
		else $error("align flag source not periodic");
	a_txmf_sets: assert property (@(posedge i_core_clk) disable iff (i_reset)
		tx_mf_cnt_reg == 32'(MF_CYCLES - 1) |=> ##1 event_status_reg[fsim_pkg::EV_TX_MF])
		else $error("multiframe flag not set");
	a_tick_sets: assert property (@(posedge i_core_clk) disable iff (i_reset)
		!i_reset && tick_cnt_reg == 32'h0 |=> event_status_reg[fsim_pkg::EV_TICK])
		else $error("tick flag not set");
	a_clk_loss_sets: assert property (@(posedge i_core_clk) disable iff (i_reset)
		clk_lost_reg |=> event_status_reg[fsim_pkg::EV_TX_CLK_LOSS])
		else $error("clock loss flag not set");
	a_tx_slip_sets: assert property (@(posedge i_core_clk) disable iff (i_reset)
		i_tx_slip |=> event_status_reg[fsim_pkg::EV_TX_SLIP])
		else $error("transmit slip flag not set");

	// Timer and CRC4 sources; a select change may wrap the tick counter early
	a_tick_short: assert property (@(posedge i_core_clk) disable iff (i_reset)
		ctrl_reg[fsim_pkg::CTRL_TICK_SEL] && tick_cnt_reg >= 32'(TICK_S_CYC - 1) |=>
		tick_cnt_reg == 32'h0)
		else $error("short tick period overrun");
	a_tick_long: assert property (@(posedge i_core_clk) disable iff (i_reset)
		!ctrl_reg[fsim_pkg::CTRL_TICK_SEL] && tick_cnt_reg >= 32'(TICK_L_CYC - 1) |=>
		tick_cnt_reg == 32'h0)
		else $error("long tick period overrun");
	a_crc_from_pin: assert property (@(posedge i_core_clk) disable iff (i_reset)
		ctrl_reg[fsim_pkg::CTRL_CRC4_EN] && i_rx_crc4_mf |=>
		event_status_reg[fsim_pkg::EV_RX_CRC4_MF])
		else $error("CRC4 multiframe flag not set from pin");
	a_crc_free_run: assert property (@(posedge i_core_clk) disable iff (i_reset)
		!i_reset && !ctrl_reg[fsim_pkg::CTRL_CRC4_EN] && crc_mf_cnt_reg == 32'h0 |=>
		event_status_reg[fsim_pkg::EV_RX_CRC4_MF])
		else $error("free-running CRC4 flag not set");

	// Alarm flags, clock loss release and sticky status
	a_rx_slip_sets: assert property (@(posedge i_core_clk) disable iff (i_reset)
		!i_reset && i_rx_slip |=> alarm_status_reg[fsim_pkg::AL_RX_SLIP])
		else $error("receive slip flag not set");
	a_carrier_holds: assert property (@(posedge i_core_clk) disable iff (i_reset)
		!i_reset && alarm_status_reg[fsim_pkg::AL_CARRIER_LOSS] &&
		cl_ones_reg < 8'(fsim_pkg::CL_MIN_ONES) |=>
		alarm_status_reg[fsim_pkg::AL_CARRIER_LOSS])
		else $error("carrier loss released too early");
	a_loss_clears: assert property (@(posedge i_core_clk) disable iff (i_reset)
		i_tx_line_clock != tx_line_clock_prev_reg |=> !clk_lost_reg)
		else $error("clock loss not released by a line clock edge");
	a_event_sticky: assert property (@(posedge i_core_clk) disable iff (i_reset)
		!i_reset && !rd_event |=>
		(event_status_reg & $past(event_status_reg)) == $past(event_status_reg))
		else $error("event flag lost without a read");
	a_alarm_sticky: assert property (@(posedge i_core_clk) disable iff (i_reset)
		!i_reset && !rd_alarm |=>
		(alarm_status_reg & $past(alarm_status_reg)) == $past(alarm_status_reg))
		else $error("alarm flag lost without a read");

	// Interrupt release once no unmasked flag remains
	sequence s_nothing_pending;
		(alarm_status_reg & alarm_irq_mask_reg) == 8'h00 &&
		(event_status_reg & event_irq_mask_reg) == 8'h00;
	endsequence

	a_irq_releases: assert property (@(posedge i_core_clk) disable iff (i_reset)
		s_nothing_pending |=> !o_irq)
		else $error("interrupt held with nothing pending");
endmodule : fsim_top

// File: fsim_host_model.sv
// Host processor model on the register port
`timescale 1ns/1ps
module fsim_host_model (
	// Clock
	input  wire logic       i_core_clk,
	// Register port
	output logic      [7:0] o_addr,
	output logic      [7:0] o_wdata,
	output logic            o_wr,
	output logic            o_rd,
	input  wire logic [7:0] i_rdata
);
	// ==========================================
	// Idle bus at time zero
	initial begin
		o_addr  = 8'h00;
		o_wdata = 8'h00;
		o_wr    = 1'b0;
		o_rd    = 1'b0;
	end
	// Write, one strobe cycle; released lines invert so nothing stale lingers
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		o_addr  <= a;
		o_wdata <= d;
		o_wr    <= 1'b1;
		@(posedge i_core_clk);
		o_wr    <= 1'b0;
		o_addr  <= ~a;
		o_wdata <= ~d;
	endtask : wr
	// Read, data taken at the edge closing the answer cycle
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_core_clk);
		o_addr <= a;
		o_rd   <= 1'b1;
		@(posedge i_core_clk);
		o_rd   <= 1'b0;
		o_addr <= ~a;
		@(posedge i_core_clk);
		d = i_rdata;
	endtask : rd
endmodule : fsim_host_model

// File: fsim_top_tb_top.sv
// Testbench for the framer status and interrupt mask block
`timescale 1ns/1ps
module fsim_top_tb_top;
	// ==========================================
	// Signals
	localparam logic [7:0] AS = fsim_pkg::ALARM_STATUS_ADDR;
	localparam logic [7:0] ES = fsim_pkg::EVENT_STATUS_ADDR;
	localparam logic [7:0] AM = fsim_pkg::ALARM_IRQ_MASK_ADDR;
	localparam logic [7:0] EM = fsim_pkg::EVENT_IRQ_MASK_ADDR;
	logic       i_core_clk = 1'b0;
	logic       i_reset    = 1'b1;
	logic [7:0] addr, wdata, rdata, v;
	logic       wr, rd, irq;
	logic       bit_en = 1'b0, rx_data = 1'b0, crc_mf = 1'b0, cas_mf = 1'b0;
	logic       rx_slip = 1'b0, tx_align = 1'b0, tx_slip = 1'b0;
	logic       line_clk = 1'b0, lc_run = 1'b1;
	logic [7:0] alarms = 8'h00;
	int         err_total = 0;
	int         total_checks = 0;
	// Clock; line clock toggles until a scenario stops it
	always #5 i_core_clk = ~i_core_clk;
	always @(posedge i_core_clk) if (lc_run) line_clk <= ~line_clk;
	// ==========================================
	// Instances; short counts keep the run brief
	fsim_host_model i_fsim_host_model (.i_core_clk(i_core_clk), .o_addr(addr),
		.o_wdata(wdata), .o_wr(wr), .o_rd(rd), .i_rdata(rdata));
	fsim_top #(.FRAME_CYCLES(20), .MF_CYCLES(40), .TICK_S_CYC(50), .TICK_L_CYC(100)) i_fsim_top (
		.i_core_clk(i_core_clk), .i_reset(i_reset), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_rx_bit_en(bit_en), .i_rx_data(rx_data),
		.i_rx_crc4_mf(crc_mf), .i_rx_cas_mf(cas_mf), .i_rx_slip(rx_slip),
		.i_rx_alarms(alarms), .i_tx_line_clock(line_clk), .i_tx_align(tx_align),
		.i_tx_slip(tx_slip), .o_irq(irq));
	// ==========================================
	// Helpers
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
		i_fsim_host_model.rd(a, v);
		chk(v & m, exp);
	endtask : rchk
	// Poll until a tick shows, so later reads know its phase within 3 cycles
	task automatic sync_tick;
		int n;
		n = 0;
		i_fsim_host_model.rd(ES, v);
		v = 8'h00;
		while (v[fsim_pkg::EV_TICK] == 1'b0 && n < 60) begin
			i_fsim_host_model.rd(ES, v);
			n++;
		end
		chk(v & 8'h10, 8'h10);
	endtask : sync_tick
	task automatic cyc(input int n);
		repeat (n) @(posedge i_core_clk);
	endtask : cyc
	// One-cycle event pulses: bit0 tx slip, 1 rx slip, 2 tx align, 3 cas mf, 4 crc4 mf
	task automatic ev(input logic [4:0] s);
		@(posedge i_core_clk);
		{crc_mf, cas_mf, tx_align, rx_slip, tx_slip} <= s;
		@(posedge i_core_clk);
		{crc_mf, cas_mf, tx_align, rx_slip, tx_slip} <= 5'h00;
	endtask : ev
	task automatic give_verdict;
		$display("Checks %0d, errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : give_verdict
	// Hang guard
	initial begin
		cyc(20000);
		err_total++;
		give_verdict();
	end
	// ==========================================
	// Main sequence
	initial begin
		cyc(12);
		i_reset <= 1'b0;
		rchk(AM, 8'hFF, 8'h00);
		rchk(EM, 8'hFF, 8'h00);
		i_fsim_host_model.wr(AM, 8'hA5);
		i_fsim_host_model.wr(EM, 8'h5A);
		rchk(AM, 8'hFF, 8'hA5);
		rchk(EM, 8'hFF, 8'h5A);
		rchk(8'h3C, 8'hFF, 8'h00);
		i_fsim_host_model.wr(AM, 8'h00);
		i_fsim_host_model.wr(EM, 8'h00);
		// Periodic flags, long tick then short tick
		i_fsim_host_model.rd(ES, v);
		cyc(105);
		rchk(ES, 8'h72, 8'h72);
		// Long tick: none within 80 cycles of the last, one by 106
		sync_tick();
		cyc(80);
		rchk(ES, 8'h10, 8'h00);
		cyc(20);
		rchk(ES, 8'h10, 8'h10);
		// Short tick: none within 40 cycles of the last, one by 56
		i_fsim_host_model.wr(fsim_pkg::CTRL_ADDR, 8'h01);
		sync_tick();
		cyc(40);
		rchk(ES, 8'h10, 8'h00);
		cyc(10);
		rchk(ES, 8'h10, 8'h10);
		// CRC4 enabled: the flag follows the pin, not the free timer
		i_fsim_host_model.wr(fsim_pkg::CTRL_ADDR, 8'h03);
		i_fsim_host_model.rd(ES, v);
		cyc(50);
		rchk(ES, 8'h02, 8'h00);
		ev(5'h10);
		rchk(ES, 8'h02, 8'h02);
		// Latched events, cleared by the read
		ev(5'h0D);
		rchk(ES, 8'h89, 8'h89);
		rchk(ES, 8'h01, 8'h00);
		// Transmit line clock stops
		lc_run <= 1'b0;
		cyc(400);
		rchk(ES, 8'h04, 8'h04);
		lc_run <= 1'b1;
		cyc(4);
		i_fsim_host_model.rd(ES, v);
		rchk(ES, 8'h04, 8'h00);
		// Interrupt through the event mask
		i_fsim_host_model.wr(EM, 8'h01);
		i_fsim_host_model.rd(AS, v);
		ev(5'h01);
		cyc(3);
		chk({7'h00, irq}, 8'h01);
		i_fsim_host_model.rd(ES, v);
		cyc(2);
		chk({7'h00, irq}, 8'h00);
		i_fsim_host_model.wr(EM, 8'h00);
		ev(5'h01);
		cyc(3);
		chk({7'h00, irq}, 8'h00);
		// Interrupt through the alarm mask, receive slip
		i_fsim_host_model.wr(AM, 8'h10);
		ev(5'h02);
		cyc(3);
		chk({7'h00, irq}, 8'h01);
		rchk(AS, 8'h10, 8'h10);
		cyc(2);
		chk({7'h00, irq}, 8'h00);
		// Carrier loss holds until enough ones arrive
		i_fsim_host_model.wr(AM, 8'h00);
		alarms <= 8'h02;
		cyc(2);
		alarms <= 8'h00;
		rchk(AS, 8'h02, 8'h02);
		rchk(AS, 8'h02, 8'h02);
		bit_en <= 1'b1;
		rx_data <= 1'b1;
		cyc(20);
		rchk(AS, 8'h02, 8'h02);
		cyc(20);
		bit_en <= 1'b0;
		i_fsim_host_model.rd(AS, v);
		rchk(AS, 8'h02, 8'h00);
		give_verdict();
	end
endmodule : fsim_top_tb_top
